//--- shared/uv_fault_consts.svh
// Constants for the input undervoltage threshold and fault action block.
// Assumes a 100 MHz clock and a decoded management-bus command port.
`ifndef UV_FAULT_CONSTS_SVH
`define UV_FAULT_CONSTS_SVH

`define UV_CMD_WARN        8'h58
`define UV_CMD_FAULT       8'h59
`define UV_CMD_ACTION      8'h5A

`define UV_EXP_MSB         15
`define UV_EXP_LSB         11
`define UV_MANT_MSB        10
`define UV_RESP_MSB        7
`define UV_RESP_LSB        6
`define UV_RETRY_MSB       5
`define UV_RETRY_LSB       3
`define UV_DELAY_MSB       2
`define UV_DELAY_LSB       0
`define UV_RETRY_INFINITE  3'h7

`define UV_THRESH_RESET    11'h000
`define UV_ACTION_RESET    8'h00

`define UV_CLK_PERIOD_NS   10
`define UV_MS_NS           1000000

`define UV_DELAY1_BASE_MS  12'h00A
`define UV_DELAY2_MS_0     12'd252
`define UV_DELAY2_MS_1     12'd558
`define UV_DELAY2_MS_2     12'd924
`define UV_DELAY2_MS_3     12'd1260
`define UV_DELAY2_MS_4     12'd1596
`define UV_DELAY2_MS_5     12'd1932
`define UV_DELAY2_MS_6     12'd2268
`define UV_DELAY2_MS_7     12'd2604

`endif

//--- shared/uv_fault_pkg.sv
// Types for the input undervoltage fault action block.
// Assumes nothing of its surroundings.
`default_nettype none
package uv_fault_pkg;

  typedef enum logic [1:0] {
    RESP_IGNORE,
    RESP_DELAYED_RETRY,
    RESP_SHUTDOWN_RETRY,
    RESP_OFF_UNTIL_CLEAR
  } response_type;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_FIRST_DELAY,
    ST_RESTART_WAIT,
    ST_WAIT_CLEAR,
    ST_LATCHED_OFF
  } action_state_type;

endpackage
`default_nettype wire

//--- logic/uv_ms_timer.sv
// Millisecond down-counter used for the fault action delays.
// Assumes a synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module uv_ms_timer #(
  parameter int CYCLES_PER_MS = 100000,
  parameter int MS_WIDTH      = 12
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                start_i,
  input  wire logic [MS_WIDTH-1:0] ms_i,
  input  wire logic                abort_i,
  output logic                     done_o
);
  localparam int PW = $clog2(CYCLES_PER_MS + 1);

  logic [PW-1:0]       pre_q;
  logic [MS_WIDTH-1:0] ms_q;
  logic                busy_q;
  logic                done_q;

  wire ms_tick = (pre_q == PW'(CYCLES_PER_MS - 1));
  wire last_ms = (ms_q <= MS_WIDTH'(1));

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pre_q  <= '0;
      ms_q   <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (ce_i)
    begin
      done_q <= 1'b0;
      if (abort_i)
      begin
        busy_q <= 1'b0;
      end
      else if (start_i)
      begin
        pre_q  <= '0;
        ms_q   <= ms_i;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        pre_q <= ms_tick ? '0 : pre_q + PW'(1);
        if (ms_tick)
        begin
          ms_q <= ms_q - MS_WIDTH'(1);
          if (last_ms)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end

  assign done_o = done_q;
endmodule // uv_ms_timer
`default_nettype wire

//--- logic/input_undervoltage_fault_config.sv
// Input undervoltage threshold registers and fault action sequencer.
// Assumes a bus engine outside decodes commands into single-cycle read and
// write strobes, and a measurement path delivers line voltage mantissas
// in the same linear exponent as the thresholds.
`timescale 1ns/1ps
`default_nettype none
`include "uv_fault_consts.svh"
module input_undervoltage_fault_config #(
  parameter int CYCLES_PER_MS = `UV_MS_NS / `UV_CLK_PERIOD_NS,
  parameter int MANT_WIDTH    = 11
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic [7:0]            cmd_code_i,
  input  wire logic                  wr_en_i,
  input  wire logic [15:0]           wr_data_i,
  input  wire logic                  rd_en_i,
  input  wire logic [4:0]            vin_exponent_i,
  input  wire logic [MANT_WIDTH-1:0] line_input_voltage_i,
  input  wire logic                  line_input_valid_i,
  output logic [15:0]                rd_data_o,
  output logic                       rd_valid_o,
  output logic                       uv_warn_o,
  output logic                       uv_fault_o,
  output logic                       output_enable_o,
  output logic                       latched_off_o
);

  logic [MANT_WIDTH-1:0] warn_mant_q;
  logic [MANT_WIDTH-1:0] fault_mant_q;
  logic [7:0]            action_q;
  logic [15:0]           rd_data_q;
  logic                  rd_valid_q;
  logic                  warn_q;
  logic                  fault_q;
  logic                  out_en_q;
  logic                  latched_q;
  logic [2:0]            retries_left_q;
  logic [2:0]            retries_left_d;
  logic                  timer_start;
  logic [11:0]           timer_ms;
  logic                  timer_done;
  uv_fault_pkg::action_state_type state_q;
  uv_fault_pkg::action_state_type state_d;

  // Restart interval per delay code, not a clean progression
  function automatic logic [11:0] restart_ms(input logic [2:0] code);
    case (code)
      3'h0:    restart_ms = `UV_DELAY2_MS_0;
      3'h1:    restart_ms = `UV_DELAY2_MS_1;
      3'h2:    restart_ms = `UV_DELAY2_MS_2;
      3'h3:    restart_ms = `UV_DELAY2_MS_3;
      3'h4:    restart_ms = `UV_DELAY2_MS_4;
      3'h5:    restart_ms = `UV_DELAY2_MS_5;
      3'h6:    restart_ms = `UV_DELAY2_MS_6;
      default: restart_ms = `UV_DELAY2_MS_7;
    endcase
  endfunction

  // Read-back layout shared by both threshold registers
  function automatic logic [15:0] thresh_word(input logic [4:0] exp_n, input logic [MANT_WIDTH-1:0] mant);
    thresh_word = {exp_n, mant};
  endfunction

  wire hit_warn   = (cmd_code_i == `UV_CMD_WARN);
  wire hit_fault  = (cmd_code_i == `UV_CMD_FAULT);
  wire hit_action = (cmd_code_i == `UV_CMD_ACTION);

  wire uv_fault_pkg::response_type resp =
    uv_fault_pkg::response_type'(action_q[`UV_RESP_MSB:`UV_RESP_LSB]);
  wire [2:0] retry_code = action_q[`UV_RETRY_MSB:`UV_RETRY_LSB];
  wire [2:0] delay_code = action_q[`UV_DELAY_MSB:`UV_DELAY_LSB];
  wire       retry_inf  = (retry_code == `UV_RETRY_INFINITE);
  wire [11:0] first_delay_ms = `UV_DELAY1_BASE_MS << delay_code;
  wire [11:0] second_delay_ms = restart_ms(delay_code);

  // Unmapped commands read as zero
  wire [15:0] rd_mux =
    hit_warn   ? thresh_word(vin_exponent_i, warn_mant_q) :
    hit_fault  ? thresh_word(vin_exponent_i, fault_mant_q) :
    hit_action ? {8'h00, action_q} :
    16'h0000;

  wire below_warn  = line_input_voltage_i < warn_mant_q;
  wire below_fault = line_input_voltage_i < fault_mant_q;

  // Register writes; bits 15:11 of a threshold write are dropped
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      warn_mant_q  <= `UV_THRESH_RESET;
      fault_mant_q <= `UV_THRESH_RESET;
      action_q     <= `UV_ACTION_RESET;
    end
    else if (ce_i && wr_en_i)
    begin
      if (hit_warn)
        warn_mant_q <= wr_data_i[`UV_MANT_MSB:0];
      if (hit_fault)
        fault_mant_q <= wr_data_i[`UV_MANT_MSB:0];
      if (hit_action)
        action_q <= wr_data_i[`UV_RESP_MSB:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rd_valid_q <= rd_en_i;
      if (rd_en_i)
        rd_data_q <= rd_mux;
    end
  end

  // Comparisons update only on a fresh sample, so flags hold between samples
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      warn_q  <= 1'b0;
      fault_q <= 1'b0;
    end
    else if (ce_i && line_input_valid_i)
    begin
      warn_q  <= below_warn;
      fault_q <= below_fault;
    end
  end

  wire retries_spent = !retry_inf && (retries_left_q == 3'h0);

  // Action sequencer
  always_comb
  begin
    state_d        = state_q;
    retries_left_d = retries_left_q;
    timer_start    = 1'b0;
    timer_ms       = second_delay_ms;
    case (state_q)
      uv_fault_pkg::ST_RUN:
      begin
        if (fault_q)
        begin
          retries_left_d = retry_code;
          case (resp)
            uv_fault_pkg::RESP_DELAYED_RETRY:
            begin
              state_d     = uv_fault_pkg::ST_FIRST_DELAY;
              timer_start = 1'b1;
              timer_ms    = first_delay_ms;
            end
            uv_fault_pkg::RESP_SHUTDOWN_RETRY:
            begin
              state_d     = uv_fault_pkg::ST_RESTART_WAIT;
              timer_start = 1'b1;
            end
            uv_fault_pkg::RESP_OFF_UNTIL_CLEAR:
              state_d = uv_fault_pkg::ST_WAIT_CLEAR;
            default:
              state_d = uv_fault_pkg::ST_RUN;
          endcase
        end
      end
      uv_fault_pkg::ST_FIRST_DELAY:
      begin
        if (!fault_q)
          state_d = uv_fault_pkg::ST_RUN;
        else if (timer_done)
        begin
          state_d     = uv_fault_pkg::ST_RESTART_WAIT;
          timer_start = 1'b1;
        end
      end
      uv_fault_pkg::ST_RESTART_WAIT:
      begin
        if (timer_done)
        begin
          if (!fault_q)
            state_d = uv_fault_pkg::ST_RUN;
          else if (retries_spent)
            state_d = uv_fault_pkg::ST_LATCHED_OFF;
          else
          begin
            if (!retry_inf)
              retries_left_d = retries_left_q - 3'h1;
            timer_start = 1'b1;
          end
        end
      end
      uv_fault_pkg::ST_WAIT_CLEAR:
      begin
        if (!fault_q)
          state_d = uv_fault_pkg::ST_RUN;
      end
      uv_fault_pkg::ST_LATCHED_OFF:
        state_d = uv_fault_pkg::ST_LATCHED_OFF;
      default:
        state_d = uv_fault_pkg::ST_RUN;
    endcase
  end

  wire out_on_d = (state_d == uv_fault_pkg::ST_RUN) || (state_d == uv_fault_pkg::ST_FIRST_DELAY);
  wire abort_timer = (state_d == uv_fault_pkg::ST_RUN);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_q        <= uv_fault_pkg::ST_RUN;
      retries_left_q <= 3'h0;
      out_en_q       <= 1'b1;
      latched_q      <= 1'b0;
    end
    else if (ce_i)
    begin
      state_q        <= state_d;
      retries_left_q <= retries_left_d;
      out_en_q       <= out_on_d;
      // Own flop so the pin does not ride on the state decode
      latched_q      <= (state_d == uv_fault_pkg::ST_LATCHED_OFF);
    end
  end

  // Long delays are in milliseconds; shorten CYCLES_PER_MS in simulation
  uv_ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS),
    .MS_WIDTH      (12)
  ) delay_timer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .start_i   (timer_start),
    .ms_i      (timer_ms),
    .abort_i   (abort_timer),
    .done_o    (timer_done)
  );

  assign rd_data_o       = rd_data_q;
  assign rd_valid_o      = rd_valid_q;
  assign uv_warn_o       = warn_q;
  assign uv_fault_o      = fault_q;
  assign output_enable_o = out_en_q;
  assign latched_off_o   = latched_q;

endmodule // input_undervoltage_fault_config
`default_nettype wire

//--- test/uv_fault_asserts.sv
// Checker for the undervoltage threshold and fault action block.
// Assumes it is bound into that block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "uv_fault_consts.svh"
module uv_fault_asserts #(
  parameter int CYCLES_PER_MS = 2
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic        wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        rd_en_i,
  input wire logic [4:0]  vin_exponent_i,
  input wire logic [10:0] line_input_voltage_i,
  input wire logic        line_input_valid_i,
  input wire logic [15:0] rd_data_o,
  input wire logic        rd_valid_o,
  input wire logic        uv_warn_o,
  input wire logic        uv_fault_o,
  input wire logic        output_enable_o,
  input wire logic        latched_off_o
);
  logic [10:0] warn_q;
  logic [10:0] fault_q;
  logic [7:0]  act_q;
  logic [15:0] off_cnt_q;
  logic [15:0] exp_rd;
  logic        wr;
  logic [1:0]  code;
  assign wr = ce_i && wr_en_i;
  assign code = act_q[7:6];
  assign exp_rd = (cmd_code_i == `UV_CMD_WARN) ? {vin_exponent_i, warn_q} :
                  (cmd_code_i == `UV_CMD_FAULT) ? {vin_exponent_i, fault_q} :
                  (cmd_code_i == `UV_CMD_ACTION) ? {8'h00, act_q} : 16'h0000;
  // Shadow of the writable fields
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      warn_q  <= 11'h000;
      fault_q <= 11'h000;
      act_q   <= 8'h00;
    end
    else if (wr && cmd_code_i == `UV_CMD_WARN)
      warn_q <= wr_data_i[10:0];
    else if (wr && cmd_code_i == `UV_CMD_FAULT)
      fault_q <= wr_data_i[10:0];
    else if (wr && cmd_code_i == `UV_CMD_ACTION)
      act_q <= wr_data_i[7:0];
  end
  // Only grows while off, so a frozen clock enable cannot fake a short gap
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || output_enable_o)
      off_cnt_q <= 16'h0000;
    else
      off_cnt_q <= off_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_read_answer: assert property (ce_i && rd_en_i |=> rd_valid_o && rd_data_o == $past(exp_rd))
    else $error("read answer differs");
  a_warn_compare: assert property (ce_i && line_input_valid_i |=>
    uv_warn_o == ($past(line_input_voltage_i) < $past(warn_q))) else $error("warning flag wrong");
  a_fault_compare: assert property (ce_i && line_input_valid_i |=>
    uv_fault_o == ($past(line_input_voltage_i) < $past(fault_q))) else $error("fault flag wrong");
  a_off_needs_code: assert property ($fell(output_enable_o) |-> $past(code) != 2'b00 && $past(uv_fault_o))
    else $error("output dropped without cause");
  a_delay_keeps_on: assert property ($rose(uv_fault_o) && code == 2'b01 && output_enable_o |->
    output_enable_o [*8]) else $error("output dropped inside first delay");
  a_shutdown_fast: assert property ($rose(uv_fault_o) && code == 2'b10 && output_enable_o |->
    ##[1:3] !output_enable_o) else $error("shutdown too slow");
  a_clear_reenable: assert property ($fell(uv_fault_o) && code == 2'b11 && !output_enable_o && !latched_off_o |->
    ##[1:3] output_enable_o) else $error("output not back after clear");
  a_latch_holds: assert property (latched_off_o |=> latched_off_o && !output_enable_o)
    else $error("latched off released");
  a_restart_gap: assert property ($rose(output_enable_o) && code == 2'b10 |->
    off_cnt_q >= 252 * CYCLES_PER_MS) else $error("restart gap too short");
  c_latched: cover property ($rose(latched_off_o));
  c_restart: cover property ($rose(output_enable_o));
  c_warn: cover property ($rose(uv_warn_o));
endmodule // uv_fault_asserts
bind input_undervoltage_fault_config uv_fault_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_asserts (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_code_i(cmd_code_i), .wr_en_i(wr_en_i),
  .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .vin_exponent_i(vin_exponent_i),
  .line_input_voltage_i(line_input_voltage_i), .line_input_valid_i(line_input_valid_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .uv_warn_o(uv_warn_o), .uv_fault_o(uv_fault_o),
  .output_enable_o(output_enable_o), .latched_off_o(latched_off_o));
`default_nettype wire

//--- test/uv_host_model.sv
// Host on the management bus plus the line-voltage sampler.
// Assumes requests change 1 ns after a rising edge of sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module uv_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  output logic [7:0]       cmd_code_o,
  output logic             wr_en_o,
  output logic [15:0]      wr_data_o,
  output logic             rd_en_o,
  output logic [10:0]      volt_o,
  output logic             volt_valid_o
);
  initial
  begin
    cmd_code_o   = 8'h00;
    wr_en_o      = 1'b0;
    wr_data_o    = 16'h0000;
    rd_en_o      = 1'b0;
    volt_o       = 11'h7FF;
    volt_valid_o = 1'b0;
  end
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] g);
    @(posedge sys_clk_i);
    #1;
    cmd_code_o = c;
    wr_data_o  = d;
    wr_en_o    = w;
    rd_en_o    = !w;
    @(posedge sys_clk_i);
    #1;
    wr_en_o   = 1'b0;
    rd_en_o   = 1'b0;
    wr_data_o = ~d;
    g = rd_valid_i ? rd_data_i : 16'hXXXX;
  endtask
  task automatic sample(input logic [10:0] v);
    @(posedge sys_clk_i);
    #1;
    volt_o       = v;
    volt_valid_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    volt_valid_o = 1'b0;
    volt_o       = ~v;
  endtask
endmodule // uv_host_model
`default_nettype wire

//--- test/test_input_undervoltage_fault_config.sv
// Self-checking bench for the undervoltage threshold and fault action block.
// Assumes the host model and a shortened millisecond of 2 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "uv_fault_consts.svh"
module test_input_undervoltage_fault_config;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [4:0]  expo = 5'h1A;
  logic [7:0]  cmd;
  logic [15:0] wr_data, rd_data, got;
  logic [10:0] volt;
  logic        wr_en, rd_en, vld, rd_valid, warn, fault, oe, latched;
  int          num_errors = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  input_undervoltage_fault_config #(.CYCLES_PER_MS(2), .MANT_WIDTH(11)) i_dut (
    .sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .cmd_code_i(cmd), .wr_en_i(wr_en), .wr_data_i(wr_data),
    .rd_en_i(rd_en), .vin_exponent_i(expo), .line_input_voltage_i(volt), .line_input_valid_i(vld),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .uv_warn_o(warn), .uv_fault_o(fault),
    .output_enable_o(oe), .latched_off_o(latched));
  uv_host_model i_host (.sys_clk_i(clk), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .cmd_code_o(cmd),
    .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en), .volt_o(volt), .volt_valid_o(vld));
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_word({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic final_report;
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Fresh reset, then a fault sample under the given action setting
  task automatic arm(input logic [7:0] act);
    @(posedge clk);
    #1;
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    i_host.access(1'b1, `UV_CMD_FAULT, 16'h0100, got);
    i_host.access(1'b1, `UV_CMD_ACTION, {8'h00, act}, got);
    i_host.sample(11'h050);
  endtask
  task automatic t_regs;
    i_host.access(1'b0, `UV_CMD_WARN, 16'h0000, got);
    chk_word(got, {expo, 11'h000});
    i_host.access(1'b1, `UV_CMD_WARN, 16'hFFFF, got);
    i_host.access(1'b0, `UV_CMD_WARN, 16'h0000, got);
    chk_word(got, {expo, 11'h7FF});
    i_host.access(1'b1, `UV_CMD_FAULT, 16'h0123, got);
    expo = 5'h05;
    i_host.access(1'b0, `UV_CMD_FAULT, 16'h0000, got);
    chk_word(got, 16'h2923);
    i_host.access(1'b1, `UV_CMD_ACTION, 16'hAB5C, got);
    i_host.access(1'b0, `UV_CMD_ACTION, 16'h0000, got);
    chk_word(got, 16'h005C);
    i_host.access(1'b1, 8'h5B, 16'h1234, got);
    i_host.access(1'b0, 8'h5B, 16'h0000, got);
    chk_word(got, 16'h0000);
    // Frozen clock enable must drop the write
    ce = 1'b0;
    i_host.access(1'b1, `UV_CMD_WARN, 16'h0055, got);
    ce = 1'b1;
    i_host.access(1'b0, `UV_CMD_WARN, 16'h0000, got);
    chk_word(got, {expo, 11'h7FF});
  endtask
  task automatic t_compare;
    i_host.access(1'b1, `UV_CMD_ACTION, 16'h0000, got);
    i_host.access(1'b1, `UV_CMD_WARN, 16'h0200, got);
    i_host.access(1'b1, `UV_CMD_FAULT, 16'h0100, got);
    i_host.sample(11'h1FF);
    chk_bit(warn, 1'b1);
    chk_bit(fault, 1'b0);
    i_host.sample(11'h0FF);
    chk_bit(fault, 1'b1);
    cyc(40);
    chk_bit(oe, 1'b1);
    i_host.sample(11'h100);
    chk_bit(fault, 1'b0);
    i_host.sample(11'h200);
    chk_bit(warn, 1'b0);
  endtask
  task automatic t_delayed;
    arm(8'h40);
    cyc(15);
    chk_bit(oe, 1'b1);
    // Timer must stand still while the clock enable is low
    ce = 1'b0;
    cyc(30);
    chk_bit(oe, 1'b1);
    ce = 1'b1;
    cyc(15);
    chk_bit(oe, 1'b0);
    cyc(400);
    chk_bit(latched, 1'b0);
    cyc(150);
    chk_bit(latched, 1'b1);
    i_host.sample(11'h300);
    cyc(3);
    chk_bit(oe, 1'b0);
  endtask
  task automatic t_shutdown;
    arm(8'h88);
    cyc(3);
    chk_bit(oe, 1'b0);
    cyc(600);
    chk_bit(latched, 1'b0);
    cyc(500);
    chk_bit(latched, 1'b1);
  endtask
  task automatic t_recover;
    arm(8'h81);
    cyc(5);
    i_host.sample(11'h300);
    cyc(1000);
    chk_bit(oe, 1'b0);
    cyc(200);
    chk_bit(oe, 1'b1);
  endtask
  task automatic t_until_clear;
    arm(8'hC0);
    cyc(20);
    chk_bit(oe, 1'b0);
    i_host.sample(11'h300);
    cyc(3);
    chk_bit(oe, 1'b1);
    arm(8'hB8);
    cyc(1600);
    chk_bit(latched, 1'b0);
  endtask
  initial
  begin
    cyc(5);
    rst = 1'b0;
    t_regs();
    t_compare();
    t_delayed();
    t_shutdown();
    t_recover();
    t_until_clear();
    final_report();
  end
  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end
endmodule // test_input_undervoltage_fault_config
`default_nettype wire
